// >>> bench/instruction_fetch_sequencer_tb_top.sv
// testbench: fetch sequencer against the program memory model, queued expectations
`timescale 1ns/10ps
module instruction_fetch_sequencer_tb_top;
  import fetch_seq_pkg::*;
  typedef struct packed {
    logic [PC_W-1:0] addr;  // expected fetch counter
    logic            valid; // expected execute flag
    logic [FA_W-1:0] raddr; // file read address of the cycle
    logic [DW-1:0]   lat;   // expected latch contents
  } exp_t;
  logic            clk_sys = 1'b0;   // system clock
  logic            rst = 1'b1;       // async reset
  logic            osc_in_pin = 1'b0; // oscillator input
  logic            master_clear_prog_voltage_pin_n = 1'b1; // master clear
  logic            resistor_capacitor_osc_mode = 1'b1;     // oscillator mode fuse
  exec_req_t       exec_req = '0;                           // flow change requests
  file_bus_t       file_bus = {1'b0, LATH_ADDR, 8'h00};     // file access
  logic [IW-1:0]   pm_data;          // program word
  logic [PM_AW-1:0] pm_addr;         // fetch address
  logic [IW-1:0]   instruction_holding_register; // latched word
  logic            instr_valid;      // execute flag
  phase_t          phase;            // one-hot phase
  logic [PC_W-1:0] program_counter;  // fetch counter
  logic [DW-1:0]   file_rdata;       // register read data
  logic            file_hit;         // register hit
  logic            file_in_range;    // address within file
  logic            dm_read_strobe;   // operand read
  logic            dm_write_strobe;  // destination write
  logic            divided_clock_output; // clock out
  logic            osc_out_or_clock_out_pin_oe; // pin drive
  exp_t            exp_q[$];         // pending expectations
  exp_t            cur;              // expectation of the running cycle
  logic [PC_W-1:0] stk[SDEPTH];      // return stack model
  logic [SP_W-1:0] sp = '0;          // stack model pointer, wraps like the device
  logic [PC_W-1:0] m_ctr;            // model counter
  logic [DW-1:0]   m_lat;            // model latch
  logic            m_valid;          // model execute flag
  logic [2:0]      osc_cnt = 3'h0;   // oscillator divider
  phase_t          prev_ph = PH4;    // phase seen last cycle
  logic            chk_on = 1'b0;    // watcher enable, off across resets
  int              depth, op_r, mismatches, n_tests;
  int unsigned     seed_v;           // seed echo

  instruction_fetch_sequencer dut_u (.clk_sys(clk_sys), .rst(rst), .osc_in_pin(osc_in_pin),
    .master_clear_prog_voltage_pin_n(master_clear_prog_voltage_pin_n),
    .resistor_capacitor_osc_mode(resistor_capacitor_osc_mode), .pm_data(pm_data), .exec_req(exec_req),
    .file_bus(file_bus), .pm_addr(pm_addr), .instruction_holding_register(instruction_holding_register),
    .instr_valid(instr_valid), .phase(phase), .program_counter(program_counter), .file_rdata(file_rdata),
    .file_hit(file_hit), .file_in_range(file_in_range), .dm_read_strobe(dm_read_strobe),
    .dm_write_strobe(dm_write_strobe), .divided_clock_output(divided_clock_output),
    .osc_out_or_clock_out_pin_oe(osc_out_or_clock_out_pin_oe));
  prog_mem_model mem_u (.pm_addr(pm_addr), .pm_data(pm_data));

  // clock and oscillator, the latter slow enough for the input synchroniser
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    osc_cnt <= osc_cnt + 3'h1;
    osc_in_pin <= osc_cnt[2];
  end

  function automatic logic [IW-1:0] word_at(input logic [PM_AW-1:0] a);
    return {a[3:0], a} ^ 14'h2A5C;
  endfunction
  function automatic logic [DW-1:0] rd_exp(input exp_t e);
    if (e.raddr == PCL_ADDR) return e.addr[DW-1:0];
    if (e.raddr == LATH_ADDR) return e.lat;
    return 8'h00;
  endfunction
  task automatic check(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  task automatic give_verdict();
    if (mismatches == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wait_ph(input phase_t p);
    do @(posedge clk_sys); while (phase === p);
    do @(posedge clk_sys); while (phase !== p);
  endtask

  // one instruction cycle: request held from phase four until phase one, expectation queued
  task automatic run_cycle(input int op, input logic [FA_W-1:0] raddr, input logic [DW-1:0] d);
    logic [JT_W-1:0] t;
    exp_t            e;
    t = JT_W'($urandom);
    wait_ph(PH4);
    e.addr = m_ctr + PC_ONE;
    e.valid = 1'b1;
    case (op)
      1, 2: begin // jump or call
        exec_req.jump <= (op == 1);
        exec_req.call <= (op == 2);
        exec_req.target <= t;
        e.addr = {m_lat[LATH_JHI:LATH_JLO], t};
      end
      3: begin // return pops
        exec_req.ret <= 1'b1;
        sp = sp - SP_ONE;
        depth--;
        e.addr = stk[sp];
      end
      4: begin // interrupt entry
        exec_req.int_ack <= 1'b1;
        e.addr = INT_VEC;
      end
      5, 6, 7: begin // writes: counter low byte, latch, plain register
        file_bus <= {1'b1, (op == 5) ? PCL_ADDR : (op == 6) ? LATH_ADDR : 7'h20, d};
        if (op == 5) e.addr = {m_lat[LATH_PHI:0], d};
        if (op == 6) m_lat = d;
      end
      default: ;
    endcase
    if (op >= 1 && op <= 5) e.valid = 1'b0;
    if (op == 2 || op == 4) begin // push address of the flushed word
      stk[sp] = m_ctr;
      sp = sp + SP_ONE;
      depth++;
    end
    e.raddr = raddr;
    e.lat = m_lat;
    m_ctr = e.addr;
    m_valid = e.valid;
    exp_q.push_back(e);
    wait_ph(PH1);
    exec_req <= '0;
    file_bus <= {1'b0, raddr, 8'h00};
  endtask

  // watcher: compares each phase entry against the oldest expectation
  always @(posedge clk_sys) begin
    prev_ph <= phase;
    if (chk_on && phase !== prev_ph) begin
      case (phase)
        PH1: begin
          if (exp_q.size() == 0)
            check(1'b0, "no expectation left");
          else begin
            cur = exp_q.pop_front();
            check(program_counter === cur.addr && pm_addr === cur.addr[PM_AW-1:0], "fetch address");
            check(instr_valid === cur.valid && prev_ph === PH4, "execute flag");
            check(osc_out_or_clock_out_pin_oe === resistor_capacitor_osc_mode
                  && divided_clock_output === resistor_capacitor_osc_mode, "clock out high");
          end
        end
        PH2: check(dm_read_strobe === 1'b1 && dm_write_strobe === 1'b0 && prev_ph === PH1, "read strobe");
        PH3: check(file_rdata === rd_exp(cur) && file_in_range === (cur.raddr <= FILE_TOP)
                   && file_hit === (cur.raddr == PCL_ADDR || cur.raddr == LATH_ADDR), "file read");
        PH4: check(dm_write_strobe === 1'b1 && divided_clock_output === 1'b0
                   && instruction_holding_register === word_at(cur.addr[PM_AW-1:0]), "fetched word");
        default: check(1'b0, "phase not one-hot");
      endcase
    end
  end

  // watchdog, well beyond the roughly 2100 cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    give_verdict();
  end

  initial begin
    seed_v = $urandom(32'hB1301F92);
    m_ctr = RESET_VEC;
    m_lat = LATH_RST;
    m_valid = 1'b0;
    depth = 0;
    exp_q.push_back({RESET_VEC, 1'b0, LATH_ADDR, LATH_RST});
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    chk_on <= 1'b1;
    for (int op = 1; op < 8; op++) begin // every request kind after an executing cycle
      run_cycle(0, PCL_ADDR, 8'h00);
      run_cycle(op, LATH_ADDR, DW'($urandom));
    end
    for (int i = 0; i < 40; i++) begin // random mix, no request in a flushed cycle
      op_r = m_valid ? $urandom_range(0, 7) : 0;
      if (op_r == 3 && depth == 0) op_r = 0;
      if (i == 20) resistor_capacitor_osc_mode <= 1'b0;
      run_cycle(op_r, FA_W'($urandom_range(0, 63)), DW'($urandom));
    end
    run_cycle(0, PCL_ADDR, 8'h00);
    run_cycle(6, PCL_ADDR, 8'h1F);
    run_cycle(5, PCL_ADDR, 8'hFF);
    run_cycle(0, PCL_ADDR, 8'h00);
    run_cycle(0, PCL_ADDR, 8'h00);
    wait_ph(PH2);
    chk_on <= 1'b0;
    master_clear_prog_voltage_pin_n <= 1'b0;
    repeat (40) @(posedge clk_sys);
    check(program_counter === RESET_VEC && instr_valid === 1'b0 && phase === PH4, "clear hold");
    exp_q.delete();
    m_ctr = RESET_VEC;
    m_lat = LATH_RST;
    m_valid = 1'b0;
    depth = 0;
    sp = '0;
    exp_q.push_back({RESET_VEC, 1'b0, LATH_ADDR, LATH_RST});
    file_bus <= {1'b0, LATH_ADDR, 8'h00};
    master_clear_prog_voltage_pin_n <= 1'b1;
    chk_on <= 1'b1;
    run_cycle(0, PCL_ADDR, 8'h00);
    run_cycle(1, PCL_ADDR, 8'h00);
    run_cycle(0, LATH_ADDR, 8'h00);
    repeat (8) @(posedge clk_sys);
    give_verdict();
  end
endmodule

// >>> bench/prog_mem_model.sv
// on-chip program memory model: one word per fetch address, read in the same cycle
`timescale 1ns/10ps
module prog_mem_model (
  input  wire logic [fetch_seq_pkg::PM_AW-1:0] pm_addr, // fetch address
  output logic      [fetch_seq_pkg::IW-1:0]    pm_data  // program word
);
  import fetch_seq_pkg::*;
  // address-derived contents, so any misrouted address fetches a visibly different word
  always_comb begin
    pm_data = {pm_addr[3:0], pm_addr} ^ 14'h2A5C;
  end
endmodule

// >>> include/fetch_seq_pkg.sv
// package: widths, addresses, vectors, phases and carriers of the fetch sequencer
package fetch_seq_pkg;
  localparam int PC_W   = 13;            // program counter width
  localparam int PM_AW  = 10;            // implemented program memory address bits
  localparam int IW     = 14;            // instruction word width
  localparam int DW     = 8;             // data path width
  localparam int FA_W   = 7;             // file address width
  localparam int JT_W   = 11;            // jump/call target field width
  localparam int SDEPTH = 8;             // return stack depth
  localparam int SP_W   = 3;             // return stack pointer width
  localparam int LATH_JHI = 4;           // latch bits taken by jump/call, top
  localparam int LATH_JLO = 3;           // latch bits taken by jump/call, bottom
  localparam int LATH_PHI = 4;           // latch top bit taken by low byte write

  localparam logic [FA_W-1:0] PCL_ADDR  = 7'h02; // pc_low_byte file address
  localparam logic [FA_W-1:0] LATH_ADDR = 7'h0A; // pc_high_latch file address
  localparam logic [FA_W-1:0] FILE_TOP  = 7'h2F; // last of 48 file locations
  localparam logic [PC_W-1:0] RESET_VEC = 13'h0000; // reset vector
  localparam logic [PC_W-1:0] INT_VEC   = 13'h0004; // interrupt vector
  localparam logic [PC_W-1:0] PC_ONE    = 13'h0001; // counter step
  localparam logic [SP_W-1:0] SP_ONE    = 3'h1;     // stack pointer step
  localparam logic [DW-1:0]   LATH_RST  = 8'h00;    // latch reset value

  // four phases of one instruction cycle
  typedef enum logic [3:0] {
    PH1 = 4'h1,
    PH2 = 4'h2,
    PH3 = 4'h4,
    PH4 = 4'h8
  } phase_t;

  // flow-change request from the execute stage, sampled at end of phase four
  typedef struct packed {
    logic            jump;    // jump_instr executing
    logic            call;    // call executing
    logic            ret;     // return family executing
    logic            int_ack; // interrupt acknowledged
    logic [JT_W-1:0] target;  // jump/call target field
  } exec_req_t;

  // effective file access of the executing instruction
  typedef struct packed {
    logic            we;    // destination write this cycle
    logic [FA_W-1:0] addr;  // effective (direct or indirect) address
    logic [DW-1:0]   wdata; // destination result
  } file_bus_t;
endpackage

// >>> rtl/instruction_fetch_sequencer.sv
// instruction fetch front end: phase clocks, program counter, return stack, pc registers
`timescale 1ns/10ps
module instruction_fetch_sequencer (
  input  wire logic                             clk_sys,                         // system clock
  input  wire logic                             rst,                             // async reset
  input  wire logic                             osc_in_pin,                      // oscillator input
  input  wire logic                             master_clear_prog_voltage_pin_n, // master clear
  input  wire logic                             resistor_capacitor_osc_mode,     // rc mode fuse
  input  wire logic [fetch_seq_pkg::IW-1:0]     pm_data,                         // program word
  input  wire fetch_seq_pkg::exec_req_t         exec_req,                        // flow change
  input  wire fetch_seq_pkg::file_bus_t         file_bus,                        // file access
  output logic      [fetch_seq_pkg::PM_AW-1:0]  pm_addr,                         // fetch address
  output logic      [fetch_seq_pkg::IW-1:0]     instruction_holding_register,    // latched word
  output logic                                  instr_valid,                     // word not flushed
  output fetch_seq_pkg::phase_t                 phase,                           // one-hot phase
  output logic      [fetch_seq_pkg::PC_W-1:0]   program_counter,                 // fetch pc
  output logic      [fetch_seq_pkg::DW-1:0]     file_rdata,                      // pc reg read
  output logic                                  file_hit,                        // pc reg hit
  output logic                                  file_in_range,                   // addr in 48
  output logic                                  dm_read_strobe,                  // operand read
  output logic                                  dm_write_strobe,                 // dest write
  output logic                                  divided_clock_output,            // clock out
  output logic                                  osc_out_or_clock_out_pin_oe      // pin drive
);
  import fetch_seq_pkg::*;

  // pin synchronisers; first stages feed only the second
  logic osc_s1, osc_s2, osc_s3;          // oscillator chain, s3 for edge
  logic mclr_s1, mclr_s2;                // master clear chain
  logic rc_s1, rc_s2;                    // mode fuse chain
  logic tick;                            // one oscillator rising edge
  logic hold;                            // master clear asserted
  logic [2:0] osc_arm;                   // which oscillator stages hold real samples

  // sequencer state
  logic [PC_W-1:0] pc, next_pc;          // program counter
  logic [DW-1:0]   latch, next_latch;    // pc_high_latch
  logic [SP_W-1:0] sp, next_sp;          // next free stack slot
  logic            start, next_start;    // first cycle after reset pending
  phase_t          next_phase;           // phase successor
  logic [IW-1:0]   next_ir;              // next latched word
  logic            next_valid;           // next flush state
  logic [PM_AW-1:0] next_pm_addr;        // next fetch address
  logic [DW-1:0]   next_rdata;           // next read data
  logic            next_hit, next_range; // next decode flags
  logic            next_rd, next_wr;     // next strobes
  logic            next_clk, next_oe;    // next clock out
  logic            push, pop;            // stack actions
  logic            redirect;             // counter loaded, not stepped
  logic            pcl_wr, lath_wr;      // pc register writes
  logic [PC_W-1:0] stack [SDEPTH];       // return addresses

  // bring pins into the clock domain
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      osc_s1  <= 1'b0;
      osc_s2  <= 1'b0;
      osc_s3  <= 1'b0;
      osc_arm <= 3'h0;
      mclr_s1 <= 1'b0;
      mclr_s2 <= 1'b0;
      rc_s1   <= 1'b0;
      rc_s2   <= 1'b0;
    end else begin
      osc_s1  <= osc_in_pin;
      osc_s2  <= osc_s1;
      osc_s3  <= osc_s2;
      osc_arm <= {osc_arm[1:0], 1'b1};
      mclr_s1 <= master_clear_prog_voltage_pin_n;
      mclr_s2 <= mclr_s1;
      rc_s1   <= resistor_capacitor_osc_mode;
      rc_s2   <= rc_s1;
    end
  end

  // oscillator must run below a quarter of clk_sys for edges to be seen
  // no edge until the chain holds real samples, so a pin already high at release is no tick
  assign tick    = osc_s2 & ~osc_s3 & osc_arm[2];
  assign hold    = ~mclr_s2;
  assign pcl_wr  = file_bus.we && (file_bus.addr == PCL_ADDR);
  assign lath_wr = file_bus.we && (file_bus.addr == LATH_ADDR);

  // next-state logic of phases, counter, stack and pc registers
  always_comb begin
    next_phase   = phase;
    next_pc      = pc;
    next_latch   = latch;
    next_sp      = sp;
    next_start   = start;
    next_ir      = instruction_holding_register;
    next_valid   = instr_valid;
    next_rdata   = file_rdata;
    next_hit     = file_hit;
    next_range   = file_in_range;
    next_rd      = 1'b0;
    next_wr      = 1'b0;
    push         = 1'b0;
    pop          = 1'b0;
    redirect     = 1'b0;
    if (hold) begin
      // held in reset; restart at the reset vector afterwards
      next_phase = PH4;
      next_pc    = RESET_VEC;
      next_latch = LATH_RST;
      next_sp    = '0;
      next_start = 1'b1;
      next_valid = 1'b0;
    end else if (tick) begin
      unique case (phase)
        PH1: begin
          next_phase = PH2;
          next_rd    = 1'b1;
          // pc registers read back during operand read
          next_hit   = pcl_wr | lath_wr | (file_bus.addr == PCL_ADDR) | (file_bus.addr == LATH_ADDR);
          next_range = (file_bus.addr <= FILE_TOP);
          if (file_bus.addr == PCL_ADDR) begin
            next_rdata = pc[DW-1:0];
          end else if (file_bus.addr == LATH_ADDR) begin
            next_rdata = latch;
          end else begin
            next_rdata = '0;                              // not ours
          end
        end
        PH2: begin
          next_phase = PH3;
        end
        PH3: begin
          next_phase = PH4;
          next_ir    = pm_data;
          next_wr    = 1'b1;
        end
        PH4: begin
          next_phase = PH1;
          redirect   = 1'b1;
          if (lath_wr) begin
            next_latch = file_bus.wdata;
          end
          if (start) begin
            next_pc    = RESET_VEC;
            next_start = 1'b0;
          end else if (exec_req.int_ack) begin
            next_pc = INT_VEC;
            push    = 1'b1;
          end else if (exec_req.jump || exec_req.call) begin
            next_pc = {latch[LATH_JHI:LATH_JLO], exec_req.target};
            push    = exec_req.call;
          end else if (exec_req.ret) begin
            next_pc = stack[sp - SP_ONE];
            pop     = 1'b1;
          end else if (pcl_wr) begin
            // upper bits never written directly, only from latch
            next_pc = {latch[LATH_PHI:0], file_bus.wdata};
          end else begin
            next_pc  = pc + PC_ONE;
            redirect = 1'b0;
          end
          // word fetched behind a flow change is dropped
          next_valid = ~redirect;
        end
        default: begin
          next_phase = PH1;                               // illegal code recovery
        end
      endcase
    end
    // stack wraps silently; a ninth push overwrites the oldest
    if (push) begin
      next_sp = sp + SP_ONE;
    end else if (pop) begin
      next_sp = sp - SP_ONE;
    end
    next_pm_addr = next_pc[PM_AW-1:0];
    next_oe      = rc_s2;
    // high across phases one and two, one period per cycle
    next_clk     = rc_s2 && ((next_phase == PH1) || (next_phase == PH2));
  end

  // registers of the sequencer
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      phase                        <= PH4;
      pc                           <= RESET_VEC;
      latch                        <= LATH_RST;
      sp                           <= '0;
      start                        <= 1'b1;
      instruction_holding_register <= '0;
      instr_valid                  <= 1'b0;
      pm_addr                      <= '0;
      file_rdata                   <= '0;
      file_hit                     <= 1'b0;
      file_in_range                <= 1'b0;
      dm_read_strobe               <= 1'b0;
      dm_write_strobe              <= 1'b0;
      divided_clock_output         <= 1'b0;
      osc_out_or_clock_out_pin_oe  <= 1'b0;
    end else begin
      phase                        <= next_phase;
      pc                           <= next_pc;
      latch                        <= next_latch;
      sp                           <= next_sp;
      start                        <= next_start;
      instruction_holding_register <= next_ir;
      instr_valid                  <= next_valid;
      pm_addr                      <= next_pm_addr;
      file_rdata                   <= next_rdata;
      file_hit                     <= next_hit;
      file_in_range                <= next_range;
      dm_read_strobe               <= next_rd;
      dm_write_strobe              <= next_wr;
      divided_clock_output         <= next_clk;
      osc_out_or_clock_out_pin_oe  <= next_oe;
    end
  end

  // return stack storage, no reset needed
  always_ff @(posedge clk_sys) begin
    if (push) begin
      stack[sp] <= pc;
    end
  end

  assign program_counter = pc;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  AST_PHASE_ROTATE: assert property (
    !hold && tick && phase == PH4 |=> phase == PH1 ##1 (phase == PH1) [*1])
    else $error("phase four not followed by phase one");

  AST_PHASE_ONEHOT: assert property (
    $onehot(phase))
    else $error("phase not one-hot");

  AST_PC_STEP: assert property (
    !hold && tick && phase == PH4 && !redirect |=> pc == $past(pc) + PC_ONE && instr_valid)
    else $error("counter did not step in phase one");

  AST_IR_LATCH: assert property (
    !hold && tick && phase == PH3 |=> instruction_holding_register == $past(pm_data) && dm_write_strobe)
    else $error("word not latched entering phase four");

  AST_FLUSH: assert property (
    !hold && tick && phase == PH4 && redirect |=> !instr_valid)
    else $error("fetched word not flushed on flow change");

  AST_JUMP_PC: assert property (
    !hold && tick && phase == PH4 && !start && !exec_req.int_ack && exec_req.jump
    |=> pc == {$past(latch[LATH_JHI:LATH_JLO]), $past(exec_req.target)})
    else $error("jump target not joined with latch bits");

  AST_INT_VEC: assert property (
    !hold && tick && phase == PH4 && !start && exec_req.int_ack |=> pc == INT_VEC && sp == $past(sp) + SP_ONE)
    else $error("interrupt did not vector and push");

  AST_WRAP: assert property (
    pm_addr == pc[PM_AW-1:0])
    else $error("fetch address not wrapped counter");

  AST_RD_PHASE: assert property (
    dm_read_strobe |-> phase == PH2 && !dm_write_strobe)
    else $error("operand read outside phase two");

  AST_HOLD: assert property (
    hold |=> pc == RESET_VEC && phase == PH4 && !instr_valid)
    else $error("master clear did not hold reset");

  AST_DIVIDED_CLOCK_OUTPUT: assert property (
    !rc_s2 |=> !osc_out_or_clock_out_pin_oe && !divided_clock_output)
    else $error("clock out driven outside rc mode");

  AST_RD_PCL: assert property (
    !hold && tick && phase == PH1 && file_bus.addr == PCL_ADDR |=> file_rdata == $past(pc[DW-1:0]) && file_hit)
    else $error("counter low byte not read back");

  AST_RET_POP: assert property (
    !hold && tick && phase == PH4 && !start && exec_req.ret
    && !exec_req.int_ack && !exec_req.jump && !exec_req.call
    |=> sp == $past(sp) - SP_ONE && !instr_valid)
    else $error("return did not pop the stack");

  COV_JUMP: cover property (tick && phase == PH4 && exec_req.jump && !start);
  COV_CALL_RET: cover property (push ##[1:200] pop);
  COV_INT: cover property (tick && phase == PH4 && exec_req.int_ack && !start);
  COV_PCL_WR: cover property (tick && phase == PH4 && pcl_wr && !start);
  COV_RET: cover property (tick && phase == PH4 && exec_req.ret && !start);
endmodule
